// >>> core/rstm_cfg_store.v
// Holds the pin-reset sequence selection and the self-test choice.
// Loaded from nonvolatile shadow data on every load strobe; read data registered.
`timescale 1ns/1ps
`include "rstm_consts.vh"
module rstm_cfg_store (
    input wire ref_clk,                    // System clock
    input wire sys_rst,                    // Synchronous reset, active high
    input wire load,                       // Shadow data valid pulse
    input wire [`RSTM_SEL_W-1:0] sel_in,   // Pin-reset selection from shadow
    input wire bist_in,                    // Self test enable from shadow
    output reg [`RSTM_SEL_W-1:0] sel,      // Stored selection
    output reg bist_en                     // Stored self test enable
);
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            sel <= `RSTM_SEL_EXT_LONG;
            bist_en <= 1'b0;
        end else if (load) begin
            sel <= sel_in;
            bist_en <= bist_in;
        end
    end
endmodule

// >>> core/rstm_consts.vh
// Constants for the reset sequence trigger map.
// Included by the sequencer and its configuration store; definitions only.
`ifndef RSTM_CONSTS_VH
`define RSTM_CONSTS_VH
// Sequence codes: which sequence runs
`define RSTM_SEQ_W 3
`define RSTM_SEQ_NONE 3'h0
`define RSTM_SEQ_DESTR 3'h1
`define RSTM_SEQ_EXT_LONG 3'h2
`define RSTM_SEQ_FUNC_LONG 3'h3
`define RSTM_SEQ_FUNC_SHORT 3'h4
// Pin-reset selection codes held in the configuration store
`define RSTM_SEL_W 2
`define RSTM_SEL_EXT_LONG 2'h0
`define RSTM_SEL_FUNC_LONG 2'h1
`define RSTM_SEL_FUNC_SHORT 2'h2
// Default phase lengths in cycles
`define RSTM_PH_W 16
`define RSTM_DESTR_CYC 16'h0040
`define RSTM_BIST_CYC 16'h0100
`define RSTM_LONG_CYC 16'h0020
`define RSTM_SHORT_CYC 16'h0008
`define RSTM_ZERO_CYC 16'h0000
`define RSTM_ONE_CYC 16'h0001
// One-hot states
`define RSTM_ST_W 4
`define RSTM_ST_RUN 4'h1
`define RSTM_ST_SEQ 4'h2
`define RSTM_ST_FINAL 4'h4
`define RSTM_ST_POWER 4'h8
`endif

// >>> core/rstm_seq.v
// Reset sequence trigger map: picks the reset sequence per trigger and drives the reset pin.
// Assumes triggers are synchronous to ref_clk; the pin is open drain with an outside pull-up.
//
// Function
// - A functional sequence pulls the pin low only when its source is enabled to drive it.
// - A destructive source starts only the destructive sequence, ended by pin release.
// - The destructive sequence runs or skips self test per shadow configuration.
// - A pin assertion starts a long external, long or short functional sequence, never destructive.
// - A pin assertion starts a sequence only when running with the pin released before.
// - A long functional source starts only the long functional sequence.
// - A short functional source starts only the short functional sequence.
// - An outside low on the pin keeps the device in the final phase until released.
// - An outside low does not block a destructive sequence, it only prolongs the final phase.
`timescale 1ns/1ps
`include "rstm_consts.vh"
module rstm_seq #(
    parameter DESTR_CYC = `RSTM_DESTR_CYC,
    parameter BIST_CYC = `RSTM_BIST_CYC,
    parameter LONG_CYC = `RSTM_LONG_CYC,
    parameter SHORT_CYC = `RSTM_SHORT_CYC
) (
    input wire ref_clk,                          // System clock
    input wire sys_rst,                          // Synchronous reset, active high
    input wire low_supply_detector,              // Low supply event, level
    input wire high_supply_detector,             // High supply event, level
    input wire func_long_req,                    // Functional source, long reset, pulse
    input wire func_short_req,                   // Functional source, short reset, pulse
    input wire functional_reset_pin_drive_enable, // Triggering source may drive pin
    input wire shadow_load,                      // Shadow config valid pulse
    input wire [`RSTM_SEL_W-1:0] shadow_sel,     // Pin-reset sequence selection
    input wire shadow_bist,                      // Self test enable
    input wire rst_pin_in,                       // Reset pin level, low = asserted
    output reg rst_pin_out,                      // Reset pin drive value, always low
    output reg rst_pin_oe_n,                     // Low while driving the pin
    output reg [`RSTM_SEQ_W-1:0] seq_kind,       // Sequence in progress
    output reg bist_run,                         // Self test running
    output reg in_final_phase,                   // Final reset phase
    output reg device_running                    // Out of reset
);
    wire [`RSTM_SEL_W-1:0] cfg_sel;
    wire cfg_bist;
    reg [`RSTM_ST_W-1:0] state;
    reg [`RSTM_ST_W-1:0] next_state;
    reg [`RSTM_PH_W-1:0] count;
    reg [`RSTM_PH_W-1:0] next_count;
    reg [`RSTM_SEQ_W-1:0] next_kind;
    reg next_drive;
    reg next_bist;
    reg drive;
    reg pin_prev;
    wire destr_ev;
    wire pin_fall;
    wire bist_pick;
    wire [`RSTM_SEQ_W-1:0] pin_kind;

    rstm_cfg_store u_cfg (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .load(shadow_load),
        .sel_in(shadow_sel),
        .bist_in(shadow_bist),
        .sel(cfg_sel),
        .bist_en(cfg_bist)
    );

    // Maps a pin-reset selection to the sequence it starts
    function [`RSTM_SEQ_W-1:0] pin_seq;
        input [`RSTM_SEL_W-1:0] s;
        begin
            case (s)
                `RSTM_SEL_FUNC_LONG: pin_seq = `RSTM_SEQ_FUNC_LONG;
                `RSTM_SEL_FUNC_SHORT: pin_seq = `RSTM_SEQ_FUNC_SHORT;
                default: pin_seq = `RSTM_SEQ_EXT_LONG;
            endcase
        end
    endfunction

    // Cycle length of the internal part of a sequence
    function [`RSTM_PH_W-1:0] seq_len;
        input [`RSTM_SEQ_W-1:0] k;
        input b;
        begin
            case (k)
                `RSTM_SEQ_DESTR: seq_len = b ? BIST_CYC[`RSTM_PH_W-1:0]
                                             : DESTR_CYC[`RSTM_PH_W-1:0];
                `RSTM_SEQ_FUNC_SHORT: seq_len = SHORT_CYC[`RSTM_PH_W-1:0];
                default: seq_len = LONG_CYC[`RSTM_PH_W-1:0];
            endcase
        end
    endfunction

    assign destr_ev = low_supply_detector | high_supply_detector;
    // Shadow data may arrive on the very edge that leaves reset; the store shows it
    // one cycle too late for the power-up decision, so take it straight from the inputs
    assign bist_pick = shadow_load ? shadow_bist : cfg_bist;
    // Decoded once so the pin branch cannot disagree with itself
    assign pin_kind = pin_seq(cfg_sel);
    // Edge of the pin seen from a released state; our own drive cannot trigger it
    assign pin_fall = pin_prev & ~rst_pin_in & ~drive;

    always @* begin
        next_state = state;
        next_count = count;
        next_kind = seq_kind;
        next_drive = drive;
        next_bist = bist_run;
        if (destr_ev) begin
            next_state = `RSTM_ST_POWER;
            next_kind = `RSTM_SEQ_DESTR;
            next_drive = 1'b1;
            next_bist = 1'b0;
            next_count = `RSTM_ZERO_CYC;
        end else begin
            case (state)
                `RSTM_ST_POWER: begin
                    next_state = `RSTM_ST_SEQ;
                    next_bist = bist_pick;
                    next_count = seq_len(`RSTM_SEQ_DESTR, bist_pick);
                end
                `RSTM_ST_RUN: begin
                    next_kind = `RSTM_SEQ_NONE;
                    next_drive = 1'b0;
                    if (pin_fall) begin
                        next_kind = pin_kind;
                        next_state = `RSTM_ST_SEQ;
                        // Only the external sequence holds the pin itself; functional
                        // ones leave it to the outside party that pulled it
                        next_drive = (pin_kind == `RSTM_SEQ_EXT_LONG);
                        next_count = seq_len(pin_kind, 1'b0);
                    end else if (func_long_req) begin
                        next_kind = `RSTM_SEQ_FUNC_LONG;
                        next_state = `RSTM_ST_SEQ;
                        next_drive = functional_reset_pin_drive_enable;
                        next_count = LONG_CYC[`RSTM_PH_W-1:0];
                    end else if (func_short_req) begin
                        next_kind = `RSTM_SEQ_FUNC_SHORT;
                        next_state = `RSTM_ST_SEQ;
                        next_drive = functional_reset_pin_drive_enable;
                        next_count = SHORT_CYC[`RSTM_PH_W-1:0];
                    end
                end
                `RSTM_ST_SEQ: begin
                    next_count = count - `RSTM_ONE_CYC;
                    if (count <= `RSTM_ONE_CYC) begin
                        next_state = `RSTM_ST_FINAL;
                        next_drive = 1'b0;
                        next_bist = 1'b0;
                    end
                end
                `RSTM_ST_FINAL: begin
                    if (rst_pin_in)
                        next_state = `RSTM_ST_RUN;
                end
                default: next_state = `RSTM_ST_POWER;
            endcase
        end
    end

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= `RSTM_ST_POWER;
            count <= `RSTM_ZERO_CYC;
            seq_kind <= `RSTM_SEQ_DESTR;
            drive <= 1'b1;
            bist_run <= 1'b0;
            pin_prev <= 1'b0;
            rst_pin_out <= 1'b0;
            rst_pin_oe_n <= 1'b0;
            in_final_phase <= 1'b0;
            device_running <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            seq_kind <= next_kind;
            drive <= next_drive;
            bist_run <= next_bist;
            pin_prev <= rst_pin_in;
            // Open drain: the value never changes, only the enable does
            rst_pin_out <= 1'b0;
            rst_pin_oe_n <= ~next_drive;
            in_final_phase <= (next_state == `RSTM_ST_FINAL);
            device_running <= (next_state == `RSTM_ST_RUN);
        end
    end
endmodule

// >>> sim/reset_sequence_trigger_map_test.sv
// Self-checking bench for the reset sequence trigger map.
// Assumes the supervisor model on the pin; short phase counts.
`timescale 1ns/1ps
`include "rstm_consts.vh"
module reset_sequence_trigger_map_test;
    reg ref_clk = 0, sys_rst = 1, lo = 0, hi = 0, fl = 0, fs = 0, en = 0, ld = 0, bi = 0, hold = 0;
    reg [1:0] sel = 2'h0;
    reg [31:0] lf = 32'h0000_009d;
    wire pin, pout, poe_n, bist, fin, run;
    wire [2:0] kind;
    integer errors = 0, n_tests = 0, i;
    always #10 ref_clk = ~ref_clk;
    rstm_seq #(.DESTR_CYC(16'h0008), .BIST_CYC(16'h0010), .LONG_CYC(16'h0008), .SHORT_CYC(16'h0004))
        DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .low_supply_detector(lo),
        .high_supply_detector(hi), .func_long_req(fl), .func_short_req(fs),
        .functional_reset_pin_drive_enable(en), .shadow_load(ld), .shadow_sel(sel),
        .shadow_bist(bi), .rst_pin_in(pin), .rst_pin_out(pout), .rst_pin_oe_n(poe_n),
        .seq_kind(kind), .bist_run(bist), .in_final_phase(fin), .device_running(run));
    rstm_sup sup (.hold(hold), .pin_oe_n(poe_n), .pin_out(pout), .pin(pin));
    function [31:0] lfsr(input [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Model: sequence a pin assertion starts for each stored selection
    function [2:0] exp_pin(input [1:0] s);
        exp_pin = (s == 2'h1) ? `RSTM_SEQ_FUNC_LONG :
            (s == 2'h2) ? `RSTM_SEQ_FUNC_SHORT : `RSTM_SEQ_EXT_LONG;
    endfunction
    task chk(input [7:0] got, input [7:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge ref_clk);
    endtask
    task wait_run;
        integer k;
        k = 0;
        while (run !== 1'b1 && k < 600) begin
            cyc(1);
            k = k + 1;
        end
        chk(k < 600, 1);
    endtask
    task pulse(input l, input s);
        fl = l;
        fs = s;
        cyc(1);
        fl = 0;
        fs = 0;
        cyc(1);
    endtask
    initial begin
        cyc(4);
        for (i = 0; i < 4; i = i + 1) begin
            sys_rst = 1;
            sel = i;
            bi = i[0];
            lf = lfsr(lf);
            hold = lf[0];
            en = lf[1];
            cyc(4);
            sys_rst = 0;
            ld = 1;
            cyc(1);
            ld = 0;
            cyc(2);
            chk({run, kind}, {1'b0, `RSTM_SEQ_DESTR});
            chk(bist, bi);
            cyc(20);
            chk({run, fin}, {!hold, hold});
            hold = 0;
            wait_run;
            hold = 1;
            cyc(2);
            chk({poe_n, kind}, {exp_pin(sel) != 3'h2, exp_pin(sel)});
            hold = 0;
            wait_run;
            pulse(1, 1);
            chk({poe_n, kind}, {!en, `RSTM_SEQ_FUNC_LONG});
            wait_run;
            pulse(0, 1);
            hold = 1;
            chk({poe_n, kind}, {!en, `RSTM_SEQ_FUNC_SHORT});
            cyc(2);
            chk(kind, `RSTM_SEQ_FUNC_SHORT);
            hold = 0;
            wait_run;
            $display("Selection %0d done", i);
        end
        pulse(1, 0);
        lo = 1;
        hi = lf[2];
        hold = 1;
        cyc(1);
        lo = 0;
        hi = 0;
        cyc(1);
        chk(kind, `RSTM_SEQ_DESTR);
        chk(bist, bi);
        cyc(20);
        chk({run, fin}, {1'b0, 1'b1});
        hold = 0;
        wait_run;
        $display("Supply event done");
        conclude;
    end
    initial begin
        #200000;
        errors = errors + 1;
        conclude;
    end
endmodule

// >>> sim/rstm_seq_assertions.sv
// Checker for the reset sequence trigger map.
// Sees only the sequencer's ports; one clock, synchronous reset.
`timescale 1ns/1ps
`include "rstm_consts.vh"
module rstm_seq_checker (
    input wire ref_clk, // Clock
    input wire sys_rst, // Reset
    input wire low_supply_detector, // Low supply
    input wire high_supply_detector, // High supply
    input wire func_long_req, // Long source
    input wire func_short_req, // Short source
    input wire functional_reset_pin_drive_enable, // Pin drive enable
    input wire rst_pin_in, // Pin level
    input wire rst_pin_out, // Pin value
    input wire rst_pin_oe_n, // Pin drive
    input wire [`RSTM_SEQ_W-1:0] seq_kind, // Sequence
    input wire bist_run, // Self test
    input wire in_final_phase, // Final phase
    input wire device_running // Running
);
    reg pin_prev = 1'b1;
    wire fall = pin_prev & ~rst_pin_in;
    wire sup = low_supply_detector | high_supply_detector;
    always @(posedge ref_clk) pin_prev <= rst_pin_in;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence quiet_run;
        device_running && !sup;
    endsequence
    a_supply_destr: assert property (sup |=> seq_kind == `RSTM_SEQ_DESTR && !device_running)
        else $error("supply event did not start destructive sequence");
    a_pin_start: assert property (quiet_run ##0 fall |=> !device_running &&
        seq_kind inside {`RSTM_SEQ_EXT_LONG, `RSTM_SEQ_FUNC_LONG, `RSTM_SEQ_FUNC_SHORT})
        else $error("pin assertion started wrong sequence");
    a_long_start: assert property (quiet_run ##0 (!fall && func_long_req) |=>
        seq_kind == `RSTM_SEQ_FUNC_LONG && rst_pin_oe_n == !$past(functional_reset_pin_drive_enable))
        else $error("long request wrong sequence or drive");
    a_short_start: assert property (quiet_run ##0 (!fall && !func_long_req && func_short_req) |=>
        seq_kind == `RSTM_SEQ_FUNC_SHORT && rst_pin_oe_n == !$past(functional_reset_pin_drive_enable))
        else $error("short request wrong sequence or drive");
    a_busy_ignore: assert property (!device_running && !sup |=>
        seq_kind == $past(seq_kind) || seq_kind == `RSTM_SEQ_NONE)
        else $error("sequence changed while busy");
    a_final_hold: assert property (in_final_phase && !rst_pin_in |=> !device_running)
        else $error("left final phase with pin held low");
    a_final_release: assert property (in_final_phase |-> rst_pin_oe_n)
        else $error("pin still driven in final phase");
    a_bist_destr: assert property (bist_run |-> seq_kind == `RSTM_SEQ_DESTR)
        else $error("self test outside destructive sequence");
    a_drive_low: assert property (!rst_pin_oe_n |-> !rst_pin_out)
        else $error("pin driven high");
endmodule
bind rstm_seq rstm_seq_checker u_chk (.ref_clk, .sys_rst, .low_supply_detector,
    .high_supply_detector, .func_long_req, .func_short_req, .functional_reset_pin_drive_enable,
    .rst_pin_in, .rst_pin_out, .rst_pin_oe_n, .seq_kind, .bist_run, .in_final_phase,
    .device_running);

// >>> sim/rstm_sup.sv
// Outside reset supervisor on the open-drain reset pin.
// Assumes an outside pull-up; hold comes from the bench.
`timescale 1ns/1ps
module rstm_sup (
    input wire hold,     // Pull the pin low
    input wire pin_oe_n, // Device drive, low = driving
    input wire pin_out,  // Device drive value
    output wire pin      // Resolved pin level
);
    // hold past end
    // Wired-AND: released pin returns to the pull-up level, never the last value
    assign pin = (pin_oe_n | pin_out) & ~hold;
endmodule
